/* design/dibit_buffer.sv */
/*
 two-entry dibit buffer with valid/ready on both sides.
 assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module dibit_buffer
   import phy10_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // fill side
   input  wire logic              in_valid,
   output logic                   in_ready,
   input  wire phy10_pkg::dibit_t in_data,
   // drain side
   output logic                   out_valid,
   input  wire logic              out_ready,
   output phy10_pkg::dibit_t      out_data
);

   // ==========================================================
   // state
   buf_state_t s_reg;
   buf_state_t s_next;
   logic       push;
   logic       pop;

   assign in_ready  = (s_reg.cnt != 2'h2);
   assign out_valid = (s_reg.cnt != 2'h0);
   assign out_data  = s_reg.mem[s_reg.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.mem[s_reg.wp] = in_data;
         s_next.wp = ~s_reg.wp;
      end
      if (pop) begin
         s_next.rp = ~s_reg.rp;
      end
      // simultaneous push and pop keeps the count
      s_next.cnt = s_reg.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   a_buf_no_over : assert property (@(posedge clk) disable iff (!rstn)
      (s_reg.cnt == 2'h2 && !out_ready) |=> (s_reg.cnt == 2'h2))
      else $error("buffer lost its content while stalled");

endmodule // dibit_buffer

`default_nettype wire

/* design/phy10_line_core.sv */
/*
 10 Mb/s line functions (squelch, link pulses, jabber, polarity) and
 the loopback steering of the dibit datapath, with its register port.
 assumes line comparator and bit strobes synchronous to clk at 40 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module phy10_line_core
   import phy10_pkg::*;
#(
   parameter int NLP_PERIOD_CYC = `NLP_PERIOD_CYC,
   parameter int JAB_CYC        = `JAB_CYC,
   parameter int UNJAB_CYC      = `UNJAB_CYC
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // register port
   input  wire logic [`REG_ADDR_W-1:0] reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [15:0]            reg_wdata,
   output logic [15:0]                 reg_rdata,
   // mac side
   input  wire phy10_pkg::dibit_t      mac_tx,
   output phy10_pkg::dibit_t           mac_rx,
   output logic                        mac_rx_valid,
   input  wire logic                   mac_rx_ready,
   output logic                        rx_buf_ready,
   // line receive
   input  wire logic                   rx100_bit,
   input  wire logic                   rx100_bit_valid,
   input  wire logic                   rx10_bit,
   input  wire logic                   rx10_bit_valid,
   input  wire logic                   sq_pos,
   input  wire logic                   sq_neg,
   // line transmit and status
   output phy10_pkg::dibit_t           line_tx,
   output logic                        nlp_out,
   output logic                        squelch_ok,
   output logic                        pol_reversed,
   output logic                        jabbered
);

   // ==========================================================
   // decode
   localparam logic [`CNT_W-1:0] NLP_LAST   = `CNT_W'(NLP_PERIOD_CYC - 1);
   localparam logic [`CNT_W-1:0] JAB_LAST   = `CNT_W'(JAB_CYC - 1);
   localparam logic [`CNT_W-1:0] UNJAB_LAST = `CNT_W'(UNJAB_CYC - 1);
   localparam logic [`CNT_W-1:0] NLP_W_LAST = `CNT_W'(`NLP_WIDTH_CYC - 1);
   localparam logic [3:0]        GAP_MIN    = 4'(`SQ_GAP_CYC - 1);
   localparam logic [3:0]        GAP_IDLE   = 4'(`SQ_IDLE_CYC);
   localparam logic [2:0]        TX_EXTRA   = 3'(`SQ_TX_TRANS - `SQ_BASE_TRANS - 1);

   // contradicting bit settings fall back to normal operation
   function automatic lb_mode_t lb_decode(input logic [15:0] bmc, input logic [15:0] stc);
      logic [4:0] b;
      b = stc[`STC_FAR_BIT:`STC_PCS_IN_BIT];
      lb_decode = LB_NONE;
      if ($countones(b) == 1) begin                                     // R10
         if (b[`STC_DIGITAL_BIT] && bmc[`BMC_LOOP_BIT]) begin
            lb_decode = LB_MII;                                         // R14
         end else if (b[`STC_PCS_IN_BIT]) begin
            lb_decode = LB_PCS_IN;                                      // R15
         end else if (b[`STC_PCS_OUT_BIT]) begin
            lb_decode = LB_PCS_OUT;                                     // R16
         end else if (b[`STC_DIGITAL_BIT]) begin
            lb_decode = LB_DIGITAL;                                     // R18
         end else if (b[`STC_ANALOG_BIT]) begin
            lb_decode = LB_ANALOG;                                      // R19
         end else begin
            lb_decode = LB_FAR_END;                                     // R20
         end
      end
   endfunction

   // ==========================================================
   // state
   core_state_t s_reg;
   core_state_t s_next;
   lb_mode_t    mode;
   logic        speed10;
   dibit_t      buf_in;
   dibit_t      buf_out;
   logic        buf_in_ready;
   logic        buf_out_valid;
   logic        buf_out_ready;
   dibit_t      tx_src;
   logic        any_x;
   logic        opp_x;
   logic        orig_x;
   logic        bit_v;
   logic        bit_d;
   logic        busy;

   assign mode    = lb_decode(s_reg.bmc, s_reg.stc);                    // R12
   assign speed10 = !s_reg.bmc[`BMC_SPEED_BIT];
   assign any_x   = sq_pos || sq_neg;
   assign opp_x   = s_reg.first_neg ? sq_pos : sq_neg;
   assign orig_x  = s_reg.first_neg ? sq_neg : sq_pos;

   // ==========================================================
   // datapath steering
   always_comb begin
      // coding input loop taps the raw dibits, coding output loop taps them one stage later at p1
      unique case (mode)
         LB_MII, LB_PCS_IN: buf_in = mac_tx;                            // R17
         LB_PCS_OUT:        buf_in = s_reg.p1;                          // R16
         LB_DIGITAL:        buf_in = s_reg.p2;                          // R18
         LB_ANALOG:         buf_in = s_reg.ltx;                         // R19
         default:           buf_in = s_reg.pk;
      endcase
      // near-end digital loops keep the line quiet
      unique case (mode)
         LB_FAR_END:        tx_src = buf_out_valid ? buf_out : '0;      // R20
         LB_NONE, LB_ANALOG: tx_src = s_reg.p2;
         default:           tx_src = '0;
      endcase
   end

   // far-end drains to the line, which never stalls
   assign buf_out_ready = (mode == LB_FAR_END) ? 1'b1 : mac_rx_ready;
   assign mac_rx_valid  = buf_out_valid && (mode != LB_FAR_END);
   assign mac_rx        = buf_out;
   assign rx_buf_ready  = buf_in_ready;

   dibit_buffer u_rx_buf (
      .clk       (clk),
      .rstn      (rstn),
      .in_valid  (buf_in.dv),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out)
   );

   // ==========================================================
   // next state
   always_comb begin
      s_next = s_reg;
      // register port
      if (reg_wr && reg_addr == `REG_BASIC_CTRL) begin
         s_next.bmc = reg_wdata;
      end
      if (reg_wr && reg_addr == `REG_SELF_TEST) begin
         s_next.stc = reg_wdata;
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `REG_BASIC_CTRL: s_next.rdata = s_reg.bmc;
            `REG_SELF_TEST:  s_next.rdata = s_reg.stc;
            default:         s_next.rdata = '0;
         endcase
      end

      // transmit pipeline, mac ignored under far-end loop
      s_next.p1 = (mode == LB_FAR_END) ? '0 : mac_tx;                   // R21
      s_next.p2 = s_reg.p1;
      s_next.ltx = s_reg.jab ? '0 : tx_src;                             // R7

      // squelch qualification
      if (s_reg.gap != GAP_IDLE) begin
         s_next.gap = s_reg.gap + 4'h1;
      end
      if (any_x) begin
         s_next.gap = 4'h0;
      end
      unique case (s_reg.sq)
         SQ_IDLE: begin
            // only threshold crossings start qualification
            if (any_x) begin                                            // R2
               s_next.sq = SQ_WAIT_OPP;
               s_next.first_neg = sq_neg && !sq_pos;
            end
         end
         SQ_WAIT_OPP: begin
            if (opp_x) begin
               s_next.sq = (s_reg.gap >= GAP_MIN) ? SQ_WAIT_ORIG : SQ_IDLE;  // R3
            end else if (s_reg.gap == GAP_IDLE) begin
               s_next.sq = SQ_IDLE;
            end
         end
         SQ_WAIT_ORIG: begin
            if (orig_x && s_reg.gap >= GAP_MIN) begin                   // R3
               s_next.trans = 3'h0;
               if (s_reg.p2.dv) begin
                  s_next.sq = SQ_TX_COUNT;                              // R4
               end else begin
                  s_next.sq = SQ_VALID;
                  s_next.pol_rev = s_reg.first_neg;                     // R9
               end
            end else if (any_x || s_reg.gap == GAP_IDLE) begin
               s_next.sq = SQ_IDLE;
            end
         end
         SQ_TX_COUNT: begin
            if (any_x) begin
               s_next.trans = s_reg.trans + 3'h1;
               if (s_reg.trans == TX_EXTRA) begin                       // R4
                  s_next.sq = SQ_VALID;
                  s_next.trans = 3'h0;
                  s_next.pol_rev = s_reg.first_neg;                     // R9
               end
            end else if (s_reg.gap == GAP_IDLE) begin
               s_next.sq = SQ_IDLE;
            end
         end
         SQ_VALID: begin
            if (s_reg.gap == GAP_IDLE) begin
               s_next.sq = SQ_IDLE;
            end
         end
         default: s_next.sq = SQ_IDLE;
      endcase

      // serial to dibit, 10M bits polarity corrected
      bit_v = speed10 ? (rx10_bit_valid && s_reg.sq == SQ_VALID) : rx100_bit_valid;  // R11
      bit_d = speed10 ? (rx10_bit ^ s_reg.pol_rev) : rx100_bit;        // R9
      s_next.pk = '0;
      if (speed10 && s_reg.sq != SQ_VALID) begin
         s_next.half = 1'b0;
      end else if (bit_v) begin
         if (!s_reg.half) begin
            s_next.hold = bit_d;
            s_next.half = 1'b1;
         end else begin
            s_next.pk = '{dv: 1'b1, d: {bit_d, s_reg.hold}};            // R1
            s_next.half = 1'b0;
         end
      end

      // link pulses, started only on an idle transmitter
      busy = mac_tx.dv || s_reg.p1.dv || s_reg.p2.dv || tx_src.dv;
      if (!speed10) begin
         s_next.nlp = 1'b0;
         s_next.nlp_cnt = '0;
      end else if (s_reg.nlp) begin
         s_next.nlp_cnt = s_reg.nlp_cnt + `CNT_W'(1);
         if (s_reg.nlp_cnt == NLP_W_LAST) begin                         // R5
            s_next.nlp = 1'b0;
            // count runs on: period is start to start
         end
      end else if (busy) begin
         s_next.nlp_cnt = '0;
      end else if (s_reg.nlp_cnt == NLP_LAST) begin                     // R5
         s_next.nlp = 1'b1;
         s_next.nlp_cnt = '0;
      end else begin
         s_next.nlp_cnt = s_reg.nlp_cnt + `CNT_W'(1);
      end

      // jabber, measured on the internal transmit enable
      if (!speed10) begin                                               // R8
         s_next.jab = 1'b0;
         s_next.jab_cnt = '0;
      end else if (!s_reg.jab) begin
         if (!tx_src.dv) begin
            s_next.jab_cnt = '0;
         end else if (s_reg.jab_cnt == JAB_LAST) begin                  // R6
            s_next.jab = 1'b1;
            s_next.jab_cnt = '0;
         end else begin
            s_next.jab_cnt = s_reg.jab_cnt + `CNT_W'(1);
         end
      end else if (tx_src.dv) begin
         s_next.jab_cnt = '0;                                           // R7
      end else if (s_reg.jab_cnt == UNJAB_LAST) begin                   // R7
         s_next.jab = 1'b0;
         s_next.jab_cnt = '0;
      end else begin
         s_next.jab_cnt = s_reg.jab_cnt + `CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.bmc <= `BASIC_CTRL_RST;
         s_reg.stc <= `SELF_TEST_RST;
         s_reg.sq <= SQ_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign reg_rdata    = s_reg.rdata;
   assign line_tx      = s_reg.ltx;
   assign nlp_out      = s_reg.nlp;
   assign squelch_ok   = (s_reg.sq == SQ_VALID);
   assign pol_reversed = s_reg.pol_rev;
   assign jabbered     = s_reg.jab;

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   a_sq_no_cross : assert property ((s_reg.sq == SQ_IDLE && !any_x) |=> s_reg.sq == SQ_IDLE)  // R2
      else $error("squelch left idle without a crossing");
   a_sq_early_opp : assert property ((s_reg.sq == SQ_WAIT_OPP && opp_x && s_reg.gap < GAP_MIN)  // R3
      |=> s_reg.sq == SQ_IDLE) else $error("early opposite crossing not rejected");
   a_sq_tx_five : assert property ((s_reg.sq == SQ_WAIT_ORIG && orig_x  // R4
      && s_reg.gap >= GAP_MIN && s_reg.p2.dv) |=> s_reg.sq == SQ_TX_COUNT)
      else $error("transmitting squelch skipped transition count");
   a_nlp_width : assert property ($rose(s_reg.nlp) |-> s_reg.nlp[*4] ##1 !s_reg.nlp)  // R5
      else $error("link pulse width wrong");
   a_jab_trip : assert property ((speed10 && !s_reg.jab && tx_src.dv  // R6
      && s_reg.jab_cnt == JAB_LAST) |=> s_reg.jab) else $error("jabber did not trip");
   a_jab_gate : assert property (s_reg.jab |=> !s_reg.ltx.dv)  // R7
      else $error("line driven while jabbered");
   a_jab_fast : assert property (!speed10 |=> !s_reg.jab)  // R8
      else $error("jabber active at 100M");
   a_pol_latch : assert property ((s_reg.sq != SQ_VALID) ##1 (s_reg.sq == SQ_VALID)  // R9
      |-> s_reg.pol_rev == s_reg.first_neg) else $error("polarity not taken at qualification");
   a_one_mode : assert property (($countones(s_reg.stc[`STC_FAR_BIT:`STC_PCS_IN_BIT]) != 1)  // R10
      |-> mode == LB_NONE) else $error("conflicting loopback bits selected a mode");
   a_mii_loop : assert property ((mode == LB_MII && mac_tx.dv) |-> buf_in == mac_tx)  // R14
      else $error("mac loopback did not route transmit data");
   a_far_ignore : assert property ((mode == LB_FAR_END) |=> !s_reg.p1.dv)  // R21
      else $error("mac data entered pipe during far-end loop");

   c_far_end : cover property (mode == LB_FAR_END && s_reg.ltx.dv);
   c_mii_loop : cover property (mode == LB_MII && mac_rx_valid && mac_rx_ready);
   c_sq_valid : cover property (s_reg.sq == SQ_TX_COUNT ##[1:20] s_reg.sq == SQ_VALID);
   c_jabber : cover property ($fell(s_reg.jab));

endmodule // phy10_line_core

`default_nettype wire

/* design/phy10_params.svh */
/*
 constants for the 10 Mb/s line functions and loopback selection:
 register offsets, field positions, reset values and timing counts.
 assumes a 40 MHz core clock; included by bare name.
*/
// Operation
// R1 - serial 100M receive bits packed into dibits
// R2 - squelch rejects pulses below threshold
// R3 - opposite then original crossing, each 50ns apart
// R4 - transmitting: five transitions checked, then reset
// R5 - idle 10M line: 100ns pulse every 16ms
// R6 - jabber stops transmit after 100ms active
// R7 - jabbered until enable low for 500ms
// R8 - jabber only active at 10 Mb/s
// R9 - receive polarity reversal detected and corrected
// R10 - at most one loopback mode at once
// R11 - loopbacks work at both speeds
// R12 - four low self-test bits pick near-end point
// R13 - host should disable autonegotiation before loopback
// R14 - loop bit plus bit2 gives MAC loopback
// R15 - bit0 gives coding input loopback
// R16 - bit1 gives coding output loopback
// R17 - coding loopbacks skip all signal processing
// R18 - bit2 loops whole digital path
// R19 - bit3 loops after analog front end
// R20 - bit4 far-end loop back to partner
// R21 - far-end loop ignores MAC data
`ifndef PHY10_PARAMS_SVH
`define PHY10_PARAMS_SVH

// ==========================================================
// register map
`define REG_ADDR_W      5
`define REG_BASIC_CTRL  5'h00
`define REG_SELF_TEST   5'h16
`define BASIC_CTRL_RST  16'h2000
`define SELF_TEST_RST   16'h0000
`define BMC_LOOP_BIT    14
`define BMC_SPEED_BIT   13
`define STC_PCS_IN_BIT  0
`define STC_PCS_OUT_BIT 1
`define STC_DIGITAL_BIT 2
`define STC_ANALOG_BIT  3
`define STC_FAR_BIT     4

// ==========================================================
// timing
`define CLK_PERIOD_NS   25
`define SQ_GAP_NS       50
`define SQ_GAP_CYC      ((`SQ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SQ_IDLE_NS      200
`define SQ_IDLE_CYC     (`SQ_IDLE_NS / `CLK_PERIOD_NS)
`define SQ_BASE_TRANS   3
`define SQ_TX_TRANS     5
`define NLP_WIDTH_NS    100
`define NLP_WIDTH_CYC   (`NLP_WIDTH_NS / `CLK_PERIOD_NS)
`define NLP_PERIOD_MS   16
`define NLP_PERIOD_CYC  (`NLP_PERIOD_MS * 1000000 / `CLK_PERIOD_NS)
`define JAB_MS          100
`define JAB_CYC         (`JAB_MS * 1000000 / `CLK_PERIOD_NS)
`define UNJAB_MS        500
`define UNJAB_CYC       (`UNJAB_MS * 1000000 / `CLK_PERIOD_NS)
`define CNT_W           25

`endif

/* design/phy10_pkg.sv */
/*
 types shared by the line/loopback core and its dibit buffer.
 assumes phy10_params.svh is on the include path.
*/
`include "phy10_params.svh"

package phy10_pkg;

   // ==========================================================
   // data carrier
   typedef struct packed {
      logic       dv;
      logic [1:0] d;
   } dibit_t;

   typedef enum logic [2:0] {
      LB_NONE, LB_MII, LB_PCS_IN, LB_PCS_OUT, LB_DIGITAL, LB_ANALOG, LB_FAR_END
   } lb_mode_t;

   typedef enum logic [2:0] {
      SQ_IDLE, SQ_WAIT_OPP, SQ_WAIT_ORIG, SQ_TX_COUNT, SQ_VALID
   } sq_state_t;

   // ==========================================================
   // module state
   typedef struct packed {
      dibit_t [1:0] mem;
      logic         wp;
      logic         rp;
      logic [1:0]   cnt;
   } buf_state_t;

   typedef struct packed {
      logic [15:0]         bmc;
      logic [15:0]         stc;
      logic [15:0]         rdata;
      sq_state_t           sq;
      logic [3:0]          gap;
      logic [2:0]          trans;
      logic                first_neg;
      logic                pol_rev;
      logic                half;
      logic                hold;
      dibit_t              pk;
      dibit_t              p1;
      dibit_t              p2;
      dibit_t              ltx;
      logic                nlp;
      logic [`CNT_W-1:0]   nlp_cnt;
      logic                jab;
      logic [`CNT_W-1:0]   jab_cnt;
   } core_state_t;

endpackage

/* testbench/line_partner.sv */
/*
 line-side partner: squelch crossings and 100M bit strobes.
 assumes its tasks are entered on a falling edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none

module line_partner (
   // clock
   input  wire logic clk,
   // line receive
   output logic      sq_pos,
   output logic      sq_neg,
   output logic      rx100_bit,
   output logic      rx100_bit_valid
);
   initial begin
      sq_pos          = 1'b0;
      sq_neg          = 1'b0;
      rx100_bit       = 1'b0;
      rx100_bit_valid = 1'b0;
   end

   // ==========================================================
   // alternating crossings, gap cycles apart
   task automatic burst(input logic first, input int gap, input int n);
      for (int i = 0; i < n; i++) begin
         sq_pos <= first ^ i[0];
         sq_neg <= ~(first ^ i[0]);
         @(negedge clk);
         if (gap > 1 || i == n - 1) begin
            sq_pos <= 1'b0;
            sq_neg <= 1'b0;
         end
         repeat (gap - 1) @(negedge clk);
      end
   endtask

   // ==========================================================
   // first bit sent is the low one
   task automatic send100(input logic [1:0] d);
      for (int i = 0; i < 2; i++) begin
         rx100_bit       <= d[i];
         rx100_bit_valid <= 1'b1;
         @(negedge clk);
         rx100_bit_valid <= 1'b0;
         // inverse, so a stale bit cannot pass for data
         rx100_bit       <= ~d[i];
         @(negedge clk);
      end
   endtask
endmodule // line_partner

`default_nettype wire

/* testbench/tb.sv */
/*
 bench for the line/loopback core: registers, loops, buffer, line.
 assumes line_partner and the design sources are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "phy10_params.svh"

module tb;
   import phy10_pkg::*;
   localparam int NP = 40;
   localparam int JP = 50;
   localparam int UP = 100;
   localparam logic [15:0] STC_T [8] = '{16'h4, 16'h1, 16'h2, 16'h4, 16'h8, 16'h3, 16'h14, 16'h10};
   localparam int LAT_T [8] = '{1, 1, 2, 3, 4, 0, 0, 0};
   // first, gap, count, transmitting, qualified, reversed
   localparam int SQ_T [5][6] = '{'{1,2,3,0,1,0}, '{0,2,3,0,1,1}, '{1,1,3,0,0,0},
                                  '{1,2,3,1,0,0}, '{1,2,5,1,1,0}};
   logic                   clk, rstn, reg_wr, reg_rd, mac_rx_ready, mac_rx_valid;
   logic                   rx_buf_ready, nlp_out, squelch_ok, pol_reversed, jabbered;
   logic                   sq_pos, sq_neg, rx100_bit, rx100_bit_valid;
   logic [`REG_ADDR_W-1:0] reg_addr;
   logic [15:0]            reg_wdata, reg_rdata, rv;
   logic [31:0]            rng;
   dibit_t                 mac_tx, mac_rx, line_tx, seen;
   int                     n_errors, checks_done, n, w;

   phy10_line_core #(.NLP_PERIOD_CYC(NP), .JAB_CYC(JP), .UNJAB_CYC(UP)) phy10_line_core_inst (
      .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .mac_tx(mac_tx), .mac_rx(mac_rx),
      .mac_rx_valid(mac_rx_valid), .mac_rx_ready(mac_rx_ready), .rx_buf_ready(rx_buf_ready),
      .rx100_bit(rx100_bit), .rx100_bit_valid(rx100_bit_valid), .rx10_bit(rx100_bit),
      .rx10_bit_valid(rx100_bit_valid), .sq_pos(sq_pos), .sq_neg(sq_neg), .line_tx(line_tx),
      .nlp_out(nlp_out), .squelch_ok(squelch_ok), .pol_reversed(pol_reversed),
      .jabbered(jabbered));
   line_partner line_partner_inst (.clk(clk), .sq_pos(sq_pos), .sq_neg(sq_neg),
      .rx100_bit(rx100_bit), .rx100_bit_valid(rx100_bit_valid));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) if (line_tx.dv === 1'b1) seen <= line_tx;

   // ==========================================================
   // helpers
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(negedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a);
      @(negedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(negedge clk);
      reg_rd <= 1'b0;
      rv = reg_rdata;
   endtask

   // one mac dibit; n is the cycles until it shows at mac_rx
   task automatic mac_one(output logic [15:0] exp, output logic [15:0] got);
      exp = {13'h0, 1'b1, 2'(xs())};
      @(negedge clk);
      mac_tx <= exp[2:0];
      got = 16'h0;
      n = 0;
      for (int i = 1; i <= 8 && n == 0; i++) begin
         @(negedge clk);
         mac_tx <= '0;
         if (mac_rx_valid === 1'b1) begin
            n   = i;
            got = {13'h0, mac_rx};
         end
      end
   endtask

   task automatic wait_nlp(input logic v);
      for (int i = 0; i < 3 * NP && nlp_out !== v; i++) @(negedge clk);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(20000 * 25);
      n_errors++;
      $display("mismatch watchdog expected done seen hang");
      print_verdict();
   end

   // ==========================================================
   // tests
   initial begin
      logic [15:0] e, g;
      logic [1:0]  dq [3];
      rng = 32'h1a;
      n_errors = 0;
      checks_done = 0;
      {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, mac_tx, seen} = '0;
      mac_rx_ready = 1'b1;
      repeat (5) @(negedge clk);
      rstn <= 1'b1;
      rd(`REG_BASIC_CTRL);
      chk("bmc reset", `BASIC_CTRL_RST, rv);
      chk("reset flags", 16'h1, {14'h0, mac_rx_valid, rx_buf_ready});
      rd(`REG_SELF_TEST);
      chk("stc reset", `SELF_TEST_RST, rv);
      wr(5'h05, 16'hffff);
      rd(5'h05);
      chk("unmapped", 16'h0, rv);
      wr(`REG_SELF_TEST, 16'h001f);
      rd(`REG_SELF_TEST);
      chk("stc rw", 16'h001f, rv);
      $display("test registers done");
      for (int s = 0; s < 2; s++) begin
         for (int i = 0; i < 8; i++) begin
            wr(`REG_BASIC_CTRL, (s ? 16'h2000 : 16'h0) | (i == 0 ? 16'h4000 : 16'h0));
            wr(`REG_SELF_TEST, STC_T[i]);
            mac_one(e, g);
            chk("loop latency", 16'(LAT_T[i]), 16'(n));
            if (LAT_T[i] != 0) chk("loop data", e, g);
         end
      end
      $display("test loopback done");
      wr(`REG_BASIC_CTRL, 16'h2000);
      wr(`REG_SELF_TEST, 16'h0010);
      seen <= '0;
      e = {13'h0, 1'b1, 2'(xs())};
      mac_tx <= '{dv:1'b1, d:~e[1:0]};
      line_partner_inst.send100(e[1:0]);
      repeat (6) @(negedge clk);
      chk("far line", e, {13'h0, seen});
      chk("far valid", 16'h0, {15'h0, mac_rx_valid});
      mac_tx <= '0;
      $display("test far end done");
      wr(`REG_SELF_TEST, 16'h0);
      mac_rx_ready <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         dq[i] = 2'(xs());
         line_partner_inst.send100(dq[i]);
      end
      repeat (3) @(negedge clk);
      chk("buf full", 16'h0, {15'h0, rx_buf_ready});
      for (int i = 0; i < 2; i++) begin
         chk("buf word", {13'h1, dq[i]}, {13'h0, mac_rx_valid, mac_rx.d});
         mac_rx_ready <= 1'b1;
         @(negedge clk);
      end
      chk("buf empty", 16'h0, {15'h0, mac_rx_valid});
      $display("test buffer done");
      wr(`REG_BASIC_CTRL, 16'h0);
      for (int i = 0; i < 5; i++) begin
         mac_tx <= '{dv:1'(SQ_T[i][3]), d:2'h0};
         line_partner_inst.burst(1'(SQ_T[i][0]), SQ_T[i][1], SQ_T[i][2]);
         chk("squelch", 16'(SQ_T[i][4]), {15'h0, squelch_ok});
         if (SQ_T[i][4] != 0) begin
            chk("polarity", 16'(SQ_T[i][5]), {15'h0, pol_reversed});
            e = {13'h0, 1'b1, 2'(xs())};
            line_partner_inst.send100(e[1:0] ^ {2{1'(SQ_T[i][5])}});
            chk("rx 10M", e, {13'h0, mac_rx_valid, mac_rx.d});
         end
         mac_tx <= '0;
         repeat (12) @(negedge clk);
         chk("squelch drop", 16'h0, {15'h0, squelch_ok});
      end
      $display("test squelch done");
      wait_nlp(1'b0);
      wait_nlp(1'b1);
      n = 0;
      w = 0;
      do begin
         if (nlp_out === 1'b1 && n == w) w++;
         @(negedge clk);
         n++;
      end while (!(nlp_out === 1'b1 && n > w) && n < 3 * NP);
      chk("pulse width", 16'(`NLP_WIDTH_CYC), 16'(w));
      chk("pulse period", 16'(NP), 16'(n));
      $display("test link pulse done");
      mac_tx <= '{dv:1'b1, d:2'(xs())};
      n = 0;
      while (jabbered !== 1'b1 && n < 3 * JP) begin
         @(negedge clk);
         n++;
      end
      chk("jabber trip", 16'h1, 16'(n >= JP - 2 && n <= JP + 3));
      repeat (UP + 20) @(negedge clk);
      chk("jabber hold", 16'h2, {14'h0, jabbered, line_tx.dv});
      mac_tx <= '0;
      n = 0;
      while (jabbered !== 1'b0 && n < 3 * UP) begin
         @(negedge clk);
         n++;
      end
      chk("unjab", 16'h1, 16'(n >= UP - 2 && n <= UP + 3));
      wr(`REG_BASIC_CTRL, 16'h2000);
      mac_tx <= '{dv:1'b1, d:2'h1};
      repeat (3 * JP) @(negedge clk);
      chk("jabber 100M", 16'h1, {14'h0, jabbered, line_tx.dv});
      mac_tx <= '0;
      $display("test jabber done");
      print_verdict();
   end
endmodule // tb

`default_nettype wire
